/* ashp_pkg.sv */
package ashp_pkg;
  // register select codes on the three address lines
  localparam logic [2:0] ASHP_ADDR_DATA   = 3'h0;
  localparam logic [2:0] ASHP_ADDR_DIV_LO = 3'h1;
  localparam logic [2:0] ASHP_ADDR_DIV_HI = 3'h2;
  localparam logic [2:0] ASHP_ADDR_LINE   = 3'h3;
  localparam logic [2:0] ASHP_ADDR_STAT   = 3'h4;
  localparam logic [2:0] ASHP_ADDR_MODEM  = 3'h5;
  // line control field positions
  localparam int ASHP_LC_LEN_LSB = 0;
  localparam int ASHP_LC_STOP    = 2;
  localparam int ASHP_LC_PAR_EN  = 3;
  localparam int ASHP_LC_PAR_EVN = 4;
  localparam int ASHP_LC_LOOP    = 5;
  localparam int ASHP_LC_CLK_SEL = 6;
  localparam int ASHP_LC_TX_EN   = 7;
  // reset values
  localparam logic [7:0]  ASHP_LINE_RST  = 8'h83;
  localparam logic [15:0] ASHP_DIV_RST   = 16'h0001;
  localparam logic [1:0]  ASHP_MODEM_RST = 2'h0;
  // sample ticks per serial bit and mid-bit sample point
  localparam logic [5:0]  ASHP_TICKS_BIT = 6'h10;
  localparam logic [5:0]  ASHP_TICKS_1P5 = 6'h18;
  localparam logic [5:0]  ASHP_TICKS_2   = 6'h20;
  localparam logic [3:0]  ASHP_MID_TICK  = 4'h7;

  typedef enum logic [1:0] {ASHP_LEN5, ASHP_LEN6, ASHP_LEN7, ASHP_LEN8} ashp_len_t;

  // line configuration as held in the line control register
  typedef struct packed {
    logic      tx_en;
    logic      clk_sel;
    logic      loop_en;
    logic      par_even;
    logic      par_en;
    logic      stop_long;
    ashp_len_t len;
  } ashp_line_t;

  // sticky and live line status
  typedef struct packed {
    logic tsr_empty;
    logic thr_empty;
    logic frame_err;
    logic par_err;
    logic overrun;
    logic rx_ready;
  } ashp_stat_t;
endpackage : ashp_pkg

/* ashp_top.sv */
`timescale 1ns/1ps
module ashp_top (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             chip_select_0,
  input  wire logic             chip_select_1,
  input  wire logic             chip_select_2,
  input  wire logic [2:0]       register_select,
  input  wire logic             read_strobe,
  input  wire logic             read_strobe_n,
  input  wire logic             write_strobe,
  input  wire logic             write_strobe_n,
  input  wire logic [7:0]       data_in,
  output logic      [7:0]       data_out,
  output logic                  data_oe_n,
  input  wire logic             reference_clock_in,
  output logic                  baud_clock_out,
  output logic                  serial_tx_out,
  input  wire logic             serial_rx_in,
  input  wire logic             cts_n,
  output logic                  dtr_n,
  output logic                  rts_n
);
  import ashp_pkg::*;

  typedef enum logic [2:0] {ASHP_IDLE, ASHP_START, ASHP_DATA, ASHP_PAR, ASHP_STOP} ashp_state_t;

  ashp_line_t  line;
  ashp_stat_t  stat;
  logic        thr_empty;
  logic        tsr_empty;
  logic        rx_ready;
  logic        overrun;
  logic        par_err;
  logic        frame_err;
  logic [15:0] divisor;
  logic [1:0]  modem;
  logic [7:0]  thr;
  logic [7:0]  rbr;
  logic        sel;
  logic        rd_act;
  logic        wr_act;
  logic        rd_d;
  logic        wr_d;
  logic        rd_start;
  logic        wr_start;
  logic [7:0]  len_mask;
  logic [2:0]  last_bit;
  logic        ref_d;
  logic        ref_rise;
  logic [15:0] div_cnt;
  logic        tick;
  logic        tick_lvl;
  ashp_state_t tx_state;
  logic [7:0]  tx_shift;
  logic [5:0]  tx_ticks;
  logic [2:0]  tx_bit;
  logic        tx_par;
  logic        tx_line;
  logic [5:0]  stop_ticks;
  ashp_state_t rx_state;
  logic [3:0]  rx_ticks;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_shift;
  logic        rx_par;
  logic        rx_line;
  logic        cts_seen;

  // bus decode: every select must be true before any strobe counts
  assign sel      = chip_select_0 & chip_select_1 & chip_select_2;
  assign rd_act   = sel & (read_strobe | ~read_strobe_n);
  assign wr_act   = sel & (write_strobe | ~write_strobe_n);
  assign rd_start = rd_act & ~rd_d;
  assign wr_start = wr_act & ~wr_d;
  assign len_mask = 8'hff >> (3'h3 - 3'(line.len));
  assign last_bit = 3'h4 + 3'(line.len);
  assign ref_rise = reference_clock_in & ~ref_d;
  // one and a half stop bits only with five-bit characters
  assign stop_ticks = !line.stop_long ? ASHP_TICKS_BIT :
                      (line.len == ASHP_LEN5) ? ASHP_TICKS_1P5 : ASHP_TICKS_2;
  // loop mode turns the transmitter back onto the receiver
  assign rx_line  = line.loop_en ? tx_line : serial_rx_in;
  // status word gathered from flags kept by the transmitter and the receiver
  assign stat     = {tsr_empty, thr_empty, frame_err, par_err, overrun, rx_ready};

  // strobe and reference edge history
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_d  <= 1'b0;
      wr_d  <= 1'b0;
      ref_d <= 1'b0;
    end else begin
      rd_d  <= rd_act;
      wr_d  <= wr_act;
      ref_d <= reference_clock_in;
    end
  end

  // register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      line    <= ashp_line_t'(ASHP_LINE_RST);
      divisor <= ASHP_DIV_RST;
      modem   <= ASHP_MODEM_RST;
      thr     <= 8'h00;
    end else if (wr_start) begin
      unique case (register_select)
        ASHP_ADDR_DATA:   thr            <= data_in & len_mask;
        ASHP_ADDR_DIV_LO: divisor[7:0]   <= data_in;
        ASHP_ADDR_DIV_HI: divisor[15:8]  <= data_in;
        ASHP_ADDR_LINE:   line           <= ashp_line_t'(data_in);
        ASHP_ADDR_MODEM:  modem          <= data_in[1:0];
        default: ;
      endcase
    end
  end

  // read data and bus enable, released outside a selected read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_out  <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= ~rd_act;
      unique case (register_select)
        ASHP_ADDR_DATA:   data_out <= rbr;
        ASHP_ADDR_DIV_LO: data_out <= divisor[7:0];
        ASHP_ADDR_DIV_HI: data_out <= divisor[15:8];
        ASHP_ADDR_LINE:   data_out <= line;
        ASHP_ADDR_STAT:   data_out <= {1'b0, cts_seen, stat};
        ASHP_ADDR_MODEM:  data_out <= {6'h00, modem};
        default:          data_out <= 8'h00;
      endcase
    end
  end

  // modem outputs, inactive high; clear-to-send only reported
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dtr_n    <= 1'b1;
      rts_n    <= 1'b1;
      cts_seen <= 1'b0;
    end else begin
      dtr_n    <= ~modem[0];
      rts_n    <= ~modem[1];
      cts_seen <= ~cts_n;
    end
  end

  // baud divider counts reference rising edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt  <= 16'h0000;
      tick     <= 1'b0;
      tick_lvl <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (ref_rise && divisor != 16'h0000) begin
        if (div_cnt >= divisor - 16'h0001) begin
          div_cnt  <= 16'h0000;
          tick     <= 1'b1;
          tick_lvl <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 16'h0001;
          if (div_cnt == (divisor >> 1) - 16'h0001) begin
            tick_lvl <= 1'b0;
          end
        end
      end
    end
  end

  // clock pin: buffered reference or sixteen-times baud clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      baud_clock_out <= 1'b0;
    end else begin
      baud_clock_out <= line.clk_sel ? reference_clock_in :
                        (divisor == 16'h0001 ? reference_clock_in : tick_lvl);
    end
  end

  // transmitter: holding register, shifter and framing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_state       <= ASHP_IDLE;
      tx_shift       <= 8'h00;
      tx_ticks       <= 6'h00;
      tx_bit         <= 3'h0;
      tx_par         <= 1'b0;
      tx_line        <= 1'b1;
      thr_empty      <= 1'b1;
      tsr_empty      <= 1'b1;
    end else begin
      unique case (tx_state)
        ASHP_IDLE: begin
          tx_line <= 1'b1;
          if (!thr_empty && line.tx_en) begin
            tx_shift       <= thr;
            tx_par         <= line.par_even ? 1'b0 : 1'b1;
            thr_empty      <= 1'b1;
            tsr_empty      <= 1'b0;
            tx_ticks       <= 6'h00;
            tx_state       <= ASHP_START;
          end
        end
        default: begin
          if (tick) begin
            tx_ticks <= tx_ticks + 6'h01;
            unique case (tx_state)
              ASHP_START: begin
                tx_line <= 1'b0;
                if (tx_ticks == ASHP_TICKS_BIT - 6'h01) begin
                  tx_ticks <= 6'h00;
                  tx_bit   <= 3'h0;
                  tx_state <= ASHP_DATA;
                end
              end
              ASHP_DATA: begin
                tx_line <= tx_shift[tx_bit];
                if (tx_ticks == ASHP_TICKS_BIT - 6'h01) begin
                  tx_ticks <= 6'h00;
                  tx_par   <= tx_par ^ tx_shift[tx_bit];
                  tx_bit   <= tx_bit + 3'h1;
                  if (tx_bit == last_bit) begin
                    tx_state <= line.par_en ? ASHP_PAR : ASHP_STOP;
                  end
                end
              end
              ASHP_PAR: begin
                tx_line <= tx_par;
                if (tx_ticks == ASHP_TICKS_BIT - 6'h01) begin
                  tx_ticks <= 6'h00;
                  tx_state <= ASHP_STOP;
                end
              end
              default: begin
                tx_line <= 1'b1;
                if (tx_ticks == stop_ticks - 6'h01) begin
                  tsr_empty      <= 1'b1;
                  tx_state       <= ASHP_IDLE;
                end
              end
            endcase
          end
        end
      endcase
      // a write in the load cycle still marks the holding register full
      if (wr_start && register_select == ASHP_ADDR_DATA) begin
        thr_empty <= 1'b0;
      end
    end
  end

  // line pin: mark unless enabled, outside loop, and framing a character
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_tx_out <= 1'b1;
    end else begin
      serial_tx_out <= (line.tx_en && !line.loop_en) ? tx_line : 1'b1;
    end
  end

  // receiver: start check at mid-bit, then one sample per bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_state       <= ASHP_IDLE;
      rx_ticks       <= 4'h0;
      rx_bit         <= 3'h0;
      rx_shift       <= 8'h00;
      rx_par         <= 1'b0;
      rbr            <= 8'h00;
      rx_ready       <= 1'b0;
      overrun        <= 1'b0;
      par_err        <= 1'b0;
      frame_err      <= 1'b0;
    end else begin
      // reads clear flags; a same-cycle set below overrides
      if (rd_start && register_select == ASHP_ADDR_DATA) begin
        rx_ready <= 1'b0;
      end
      if (rd_start && register_select == ASHP_ADDR_STAT) begin
        overrun   <= 1'b0;
        par_err   <= 1'b0;
        frame_err <= 1'b0;
      end
      if (tick) begin
        rx_ticks <= rx_ticks + 4'h1;
        unique case (rx_state)
          ASHP_IDLE: begin
            rx_ticks <= 4'h0;
            if (!rx_line) begin
              rx_state <= ASHP_START;
            end
          end
          ASHP_START: begin
            if (rx_ticks == ASHP_MID_TICK) begin
              rx_ticks <= 4'h0;
              rx_bit   <= 3'h0;
              rx_shift <= 8'h00;
              rx_par   <= line.par_even ? 1'b0 : 1'b1;
              rx_state <= rx_line ? ASHP_IDLE : ASHP_DATA;
            end
          end
          ASHP_DATA: begin
            if (rx_ticks == 4'hf) begin
              rx_shift[rx_bit] <= rx_line;
              rx_par           <= rx_par ^ rx_line;
              rx_bit           <= rx_bit + 3'h1;
              if (rx_bit == last_bit) begin
                rx_state <= line.par_en ? ASHP_PAR : ASHP_STOP;
              end
            end
          end
          ASHP_PAR: begin
            if (rx_ticks == 4'hf) begin
              rx_par   <= rx_par ^ rx_line;
              rx_state <= ASHP_STOP;
            end
          end
          default: begin
            if (rx_ticks == 4'hf) begin
              rbr           <= rx_shift;
              rx_ready      <= 1'b1;
              if (rx_ready) begin
                overrun <= 1'b1;
              end
              if (line.par_en && rx_par) begin
                par_err <= 1'b1;
              end
              if (!rx_line) begin
                frame_err <= 1'b1;
              end
              rx_state <= ASHP_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : ashp_top

/* ashp_checker.sv */
`timescale 1ns/1ps
// pin-level checks of the serial port against its host bus and line rules
module ashp_checker
  import ashp_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       chip_select_0,
  input wire logic       chip_select_1,
  input wire logic       chip_select_2,
  input wire logic [2:0] register_select,
  input wire logic       read_strobe,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe,
  input wire logic       write_strobe_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n,
  input wire logic       serial_tx_out,
  input wire logic       dtr_n,
  input wire logic       rts_n
);
  logic       sel, rd, wr, wr_d;
  logic [7:0] line_cfg, modem_cfg;
  logic [1:0] quiet;
  // decoded selected read and write
  assign sel = chip_select_0 & chip_select_1 & chip_select_2;
  assign rd  = sel & (read_strobe | ~read_strobe_n);
  assign wr  = sel & (write_strobe | ~write_strobe_n);
  // shadow of line and modem control as the host writes them
  always_ff @(posedge sys_clk) begin
    wr_d <= wr;
    if (rst) begin
      line_cfg  <= ASHP_LINE_RST;
      modem_cfg <= 8'h00;
    end else if (wr && !wr_d && register_select == ASHP_ADDR_LINE) begin
      line_cfg <= data_in;
    end else if (wr && !wr_d && register_select == ASHP_ADDR_MODEM) begin
      modem_cfg <= data_in;
    end
  end
  // cycles since the last captured write, saturating at three
  always_ff @(posedge sys_clk) begin
    if (rst || (wr && !wr_d)) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_reset_idle_pins: assert property (disable iff (1'b0) rst |=> serial_tx_out && data_oe_n && dtr_n && rts_n)
    else $error("pins not idle after reset");
  a_read_drives_bus: assert property (rd |=> !data_oe_n)
    else $error("selected read did not drive the bus");
  a_bus_released: assert property (!rd |=> data_oe_n)
    else $error("bus driven without a selected read");
  a_spare_regs_zero: assert property (rd && register_select[2:1] == 2'h3 |=> data_out == 8'h00)
    else $error("spare register read not zero");
  a_upper_bits_zero: assert property (rd && register_select == ASHP_ADDR_DATA && quiet == 2'h3 && line_cfg[1:0] != 2'h3 |=> (data_out >> (5 + line_cfg[1:0])) == 8'h00)
    else $error("unused data bits read non-zero");
  a_modem_pins: assert property (quiet == 2'h3 |-> dtr_n == !modem_cfg[0] && rts_n == !modem_cfg[1])
    else $error("modem outputs differ from control");
  a_tx_mark_hold: assert property (quiet == 2'h3 && (!line_cfg[ASHP_LC_TX_EN] || line_cfg[ASHP_LC_LOOP]) |-> serial_tx_out)
    else $error("line left mark while disabled or looped");
  a_bit_min_width: assert property ($changed(serial_tx_out) |=> $stable(serial_tx_out) [*7])
    else $error("serial level shorter than a bit");

  c_data_read: cover property (rd && register_select == ASHP_ADDR_DATA);
  c_frame_start: cover property ($fell(serial_tx_out));
  c_loop_idle: cover property (quiet == 2'h3 && line_cfg[ASHP_LC_LOOP]);
endmodule : ashp_checker

bind ashp_top ashp_checker u_chk (
  .sys_clk, .rst, .chip_select_0, .chip_select_1, .chip_select_2, .register_select, .read_strobe,
  .read_strobe_n, .write_strobe, .write_strobe_n, .data_in, .data_out, .data_oe_n, .serial_tx_out,
  .dtr_n, .rts_n
);

/* ashp_line_model.sv */
`timescale 1ns/1ps
// far end of the serial line: decodes frames sent and sends frames back
module ashp_line_model (
  input  wire logic        sys_clk,
  input  wire logic        serial_tx_out,
  input  wire logic [15:0] bit_cycles,
  input  wire logic [3:0]  nbits,
  input  wire logic        send,
  input  wire logic [8:0]  send_word,
  output logic             serial_rx_in,
  output logic [8:0]       got_word,
  output int               got_count,
  output int               gap
);
  int         cyc = 0;
  int         t_fall = 0;
  logic [8:0] w;
  // running cycle count for start-to-start spacing
  always @(posedge sys_clk) cyc++;
  // decode: mid-bit sampling, lsb first, stop must read mark
  initial begin
    got_count = 0;
    gap = 0;
    forever begin
      @(negedge serial_tx_out);
      gap = cyc - t_fall;
      t_fall = cyc;
      repeat (bit_cycles / 2) @(posedge sys_clk);
      w = 9'h000;
      for (int k = 0; k < nbits; k++) begin
        repeat (bit_cycles) @(posedge sys_clk);
        w[k] = serial_tx_out;
      end
      repeat (bit_cycles) @(posedge sys_clk);
      got_word = w;
      if (serial_tx_out === 1'b1) got_count++;
    end
  end
  // send: start space, data lsb first, stop then idle mark
  initial begin
    serial_rx_in = 1'b1;
    forever begin
      @(posedge send);
      @(negedge sys_clk);
      serial_rx_in = 1'b0;
      for (int k = 0; k <= nbits; k++) begin
        repeat (bit_cycles) @(negedge sys_clk);
        serial_rx_in = (k == nbits) ? 1'b1 : send_word[k];
      end
    end
  end
endmodule : ashp_line_model

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  import ashp_pkg::*;
  logic        sys_clk, rst, read_strobe, read_strobe_n, write_strobe, write_strobe_n, cts_n, send;
  logic        reference_clock_in, data_oe_n, baud_clock_out, serial_tx_out, serial_rx_in, dtr_n, rts_n;
  logic [2:0]  cs, register_select;
  logic [7:0]  data_in, data_out, rd_val;
  logic [15:0] bit_cycles;
  logic [3:0]  nbits;
  logic [8:0]  send_word, got_word, ex;
  int          got_count, gap, err_total, total_checks, n, i, k, e;
  logic [18:0] rows [10] = '{{3'h5, 8'h03, 8'h03}, {3'h5, 8'h02, 8'h02}, {3'h1, 8'h5a, 8'h5a},
    {3'h2, 8'ha5, 8'ha5}, {3'h3, 8'h1b, 8'h1b}, {3'h6, 8'hff, 8'h00}, {3'h7, 8'h12, 8'h00},
    {3'h4, 8'hff, 8'h30}, {3'h1, 8'h01, 8'h01}, {3'h2, 8'h00, 8'h00}};
  logic [10:0] rv [4] = '{{3'h3, 8'h83}, {3'h1, 8'h01}, {3'h2, 8'h00}, {3'h5, 8'h00}};
  logic [17:0] st [3] = '{{8'h84, 4'h5, 6'h18}, {8'h87, 4'h8, 6'h20}, {8'h83, 4'h8, 6'h10}};

  ashp_top DUT (
    .sys_clk, .rst, .chip_select_0(cs[0]), .chip_select_1(cs[1]), .chip_select_2(cs[2]),
    .register_select, .read_strobe, .read_strobe_n, .write_strobe, .write_strobe_n, .data_in,
    .data_out, .data_oe_n, .reference_clock_in, .baud_clock_out, .serial_tx_out, .serial_rx_in,
    .cts_n, .dtr_n, .rts_n
  );
  ashp_line_model u_line (
    .sys_clk, .serial_tx_out, .bit_cycles, .nbits, .send, .send_word, .serial_rx_in, .got_word,
    .got_count, .gap
  );

  // value comparison
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val
  // flag comparison
  task automatic chk_flag(input string what, input logic exp, input logic got);
    chk_val(what, {15'h0000, exp}, {15'h0000, got});
  endtask : chk_flag
  // one host access, held across the sampling edge; pol picks strobe polarity
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d, input logic pol,
                     input logic [2:0] sel);
    @(negedge sys_clk);
    {cs, register_select, data_in} = {sel, a, d};
    {read_strobe, read_strobe_n, write_strobe, write_strobe_n} = {!w && pol, w || pol, w && pol, !w || pol};
    @(negedge sys_clk);
    rd_val = data_out;
    if (!w) chk_flag("oe during read", sel != 3'h7, data_oe_n);
    {read_strobe, read_strobe_n, write_strobe, write_strobe_n} = 4'h5;
    @(negedge sys_clk);
    chk_flag("oe after read", 1'b1, data_oe_n);
    cs = 3'h0;
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b0, 3'h7);
  endtask : wr
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00, 1'b1, 3'h7);
    chk_val("register read", {8'h00, x}, {8'h00, rd_val});
  endtask : rd_chk
  // bounded wait for the far end to decode frames
  task automatic wait_rx(input int c);
    for (n = 0; n < 20000 && got_count < c; n++) @(negedge sys_clk);
    chk_flag("frame decoded", 1'b1, got_count >= c);
  endtask : wait_rx
  // poll status until a character is ready
  task automatic wait_ready;
    rd_val = 8'h00;
    for (n = 0; n < 300 && rd_val[0] !== 1'b1; n++) bus(1'b0, ASHP_ADDR_STAT, 8'h00, 1'b1, 3'h7);
  endtask : wait_ready
  // count baud clock rises over 400 cycles
  task automatic count_baud(input int x);
    int   c;
    logic p;
    c = 0;
    p = baud_clock_out;
    repeat (400) begin
      @(negedge sys_clk);
      if (baud_clock_out === 1'b1 && p === 1'b0) c++;
      p = baud_clock_out;
    end
    chk_flag("baud rises", 1'b1, c >= x - 1 && c <= x + 1);
  endtask : count_baud
  // write a character and watch that the line never leaves mark
  task automatic mark_watch(input logic [7:0] d);
    int lows;
    lows = 0;
    wr(ASHP_ADDR_DATA, d);
    repeat (800) begin
      @(negedge sys_clk);
      if (serial_tx_out !== 1'b1) lows++;
    end
    chk_val("low cycles", 16'h0000, 16'(lows));
  endtask : mark_watch
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  // system clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // reference oscillator at half the system clock
  always @(negedge sys_clk) reference_clock_in <= !reference_clock_in;
  // watchdog
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end
  // main sequence
  initial begin
    {reference_clock_in, rst, send, cts_n, cs, register_select, data_in} = {4'b0101, 14'h0000};
    {read_strobe, read_strobe_n, write_strobe, write_strobe_n} = 4'h5;
    {bit_cycles, nbits, send_word, err_total, total_checks} = {16'd32, 4'h8, 9'h000, 32'd0, 32'd0};
    repeat (10) @(negedge sys_clk);
    chk_val("reset pins", 16'h001e, {11'h000, data_oe_n, serial_tx_out, dtr_n, rts_n, baud_clock_out});
    rst = 1'b0;
    for (i = 0; i < 4; i++) rd_chk(rv[i][10:8], rv[i][7:0]);
    $display("reset test done");
    for (i = 0; i < 10; i++) begin
      bus(1'b1, rows[i][18:16], rows[i][15:8], i[0], 3'h7);
      bus(1'b0, rows[i][18:16], 8'h00, !i[0], 3'h7);
      chk_val("row read", {8'h00, rows[i][7:0]}, {8'h00, rd_val});
    end
    $display("register rows done");
    for (i = 0; i < 3; i++) begin
      bus(1'b1, ASHP_ADDR_DIV_LO, 8'hee, 1'b0, 3'h7 ^ (3'h1 << i));
      bus(1'b0, ASHP_ADDR_DIV_LO, 8'h00, 1'b1, 3'h7 ^ (3'h1 << i));
      rd_chk(ASHP_ADDR_DIV_LO, 8'h01);
    end
    $display("select test done");
    for (i = 0; i < 4; i++) begin
      nbits = 4'(6 + i);
      wr(ASHP_ADDR_LINE, {3'b100, i[0], 2'b10, i[1:0]});
      k = got_count;
      wr(ASHP_ADDR_DATA, 8'hb5);
      wait_rx(k + 1);
      ex = {1'b0, 8'hb5 & (8'hff >> (3 - i))};
      ex[5 + i] = ^ex ^ !i[0];
      chk_val("tx frame", {7'h00, ex}, {7'h00, got_word});
      repeat (64) @(negedge sys_clk);
    end
    for (i = 0; i < 3; i++) begin
      nbits = st[i][9:6];
      wr(ASHP_ADDR_LINE, st[i][17:10]);
      k = got_count;
      wr(ASHP_ADDR_DATA, 8'h0f);
      wr(ASHP_ADDR_DATA, 8'h15);
      wait_rx(k + 2);
      e = 2 * (16 * (1 + st[i][9:6]) + st[i][5:0]);
      chk_flag("stop gap", 1'b1, gap >= e && gap <= e + 8);
      chk_val("second frame", 16'h0015, {7'h00, got_word});
      repeat (64) @(negedge sys_clk);
    end
    $display("transmit tests done");
    wr(ASHP_ADDR_DIV_LO, 8'h02);
    wr(ASHP_ADDR_LINE, 8'h03);
    count_baud(100);
    wr(ASHP_ADDR_LINE, 8'h43);
    count_baud(200);
    $display("baud test done");
    {bit_cycles, nbits, send_word, cts_n} = {16'd64, 4'h5, 9'h1f5, 1'b0};
    wr(ASHP_ADDR_LINE, 8'h80);
    send = 1'b1;
    @(negedge sys_clk);
    send = 1'b0;
    wait_ready();
    rd_chk(ASHP_ADDR_DATA, 8'h15);
    $display("receive test done");
    wr(ASHP_ADDR_LINE, 8'ha3);
    mark_watch(8'h3c);
    wait_ready();
    rd_chk(ASHP_ADDR_DATA, 8'h3c);
    wr(ASHP_ADDR_LINE, 8'h03);
    mark_watch(8'h66);
    $display("mark hold test done");
    give_verdict();
  end
endmodule : testbench
